// ==== uartsi_pkg.sv ====
// shared types and constants for the two-channel serial status block
// assumes a 32-bit classic wishbone master and an external bit-level receiver
package uartsi_pkg;

  // one finished character from a channel's receiver, valid for one cycle
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic       parity;
    logic       stop;
  } uartsi_rxchar_s;

  // byte handed to a channel's transmit shift register
  typedef struct packed {
    logic       load;
    logic [7:0] data;
  } uartsi_txbyte_s;

  // byte addresses: channel n at n*16, global control word at 0x20
  localparam logic [3:0] OFF_STAT   = 4'h0;
  localparam logic [3:0] OFF_DATA   = 4'h4;
  localparam logic [3:0] OFF_CTRL   = 4'h8;
  localparam logic [7:0] ADR_GLOBAL = 8'h20;

  // status register fields
  localparam int ST_AVAIL = 7;
  localparam int ST_OVR   = 6;
  localparam int ST_PAR   = 5;
  localparam int ST_FRM   = 4;
  localparam int ST_RXIE  = 3;
  localparam int ST_DCD   = 2;
  localparam int ST_THE   = 1;
  localparam int ST_TXIE  = 0;

  // channel control register fields
  localparam int CT_PAR_EN  = 0;
  localparam int CT_PAR_ODD = 1;
  localparam int CT_ERR_CLR = 2;
  localparam int CT_DCD_OFF = 3;
  localparam int CT_CTS_OFF = 4;
  localparam int CT_DATA8   = 5;
  localparam logic [5:0] CTRL_RST = 6'h00;

  // global control word fields
  localparam int GL_HALT    = 0;
  localparam int GL_EDGE0   = 1;
  localparam int GL_SM      = 2;
  localparam int GL_SAR     = 4;
  localparam int GL_DMA1_DIR = 6;
  localparam int GL_IAR     = 7;
  localparam int GL_CTS_SEL = 9;
  localparam logic [9:0] GLOBAL_RST = 10'h000;

  // dma request routing codes
  localparam logic [1:0] DMA_SM_IO = 2'h3;
  localparam logic [1:0] ROUTE_CH0 = 2'h1;
  localparam logic [1:0] ROUTE_CH1 = 2'h2;

  // receive queue depth
  localparam logic [2:0] Q_DEPTH = 3'h4;

endpackage

// ==== uartsi_top.sv ====
// two-channel serial status, error flag and interrupt request logic
// assumes an external receiver that delivers each character as a one-cycle
// strobe and an external transmit shift register that signals when it is free
//
// Operation
// - receive-full bit 7 sets on load into empty queue
// - errored characters are still queued and flagged full
// - receive-full clears on last read, halt, reset, carrier
// - overrun on completed character with queue full, bit 6
// - overrun shows when last good character reaches head
// - discard after overrun until flag set then cleared
// - error flags clear by reset bit, reset, halt, carrier
// - parity mismatch with parity enabled flags bit 5
// - stop bit sampled zero flags framing bit 4
// - parity and framing flags set at queue head
// - receive enable bit 3 requests on full, reset 0
// - dma routing to channel suppresses receive-full request
// - error flags and carrier rise also request interrupt
// - carrier bit 2 high with pin, clears on read
// - transmit-empty bit 1 clears on write, sets on move
// - transmit-empty forced one in reset and halt unless channel 0 clear-to-send gates it
// - channel 0 clear-to-send high holds transmit-empty low
// - transmit enable bit 0 requests while empty, reset 0
// - parity sense zero even, one odd
// - carrier negated holds channel 0 receiver in reset
`timescale 1ns/1ps
module uartsi_top (
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  input  wire logic                       wb_cyc_i,
  input  wire logic                       wb_stb_i,
  input  wire logic                       wb_we_i,
  input  wire logic [7:0]                 wb_adr_i,
  input  wire logic [3:0]                 wb_sel_i,
  input  wire logic [31:0]                wb_dat_i,
  output logic      [31:0]                wb_dat_o,
  output logic                            wb_ack_o,
  input  uartsi_pkg::uartsi_rxchar_s [1:0] rx_char_i,
  input  wire logic [1:0]                 tx_shift_ready_i,
  output uartsi_pkg::uartsi_txbyte_s [1:0] tx_byte_o,
  input  wire logic                       carrier_detect_0_i,
  input  wire logic                       clear_to_send_0_i,
  output logic                            rx_hold_0_o,
  output logic      [1:0]                 irq_o
);

  logic        ack_reg;
  logic [31:0] rdat_reg;
  logic [9:0]  glb_reg;
  logic [7:0]  ch_rd [2];
  logic [1:0]  hold_w;

  // one request per wishbone cycle: ack stops a second take
  wire bus_req = wb_cyc_i & wb_stb_i & ~ack_reg;
  wire bus_wr  = bus_req & wb_we_i & wb_sel_i[0];
  wire bus_rd  = bus_req & ~wb_we_i;
  wire hit_glb = wb_adr_i == uartsi_pkg::ADR_GLOBAL;
  wire halt    = glb_reg[uartsi_pkg::GL_HALT];
  wire dcd_fn  = ~glb_reg[uartsi_pkg::GL_EDGE0];
  wire cts_fn  = ~glb_reg[uartsi_pkg::GL_CTS_SEL];

  // global word; upper bits ride on lane 1
  wire [9:0] glb_next = {
    wb_sel_i[1] ? wb_dat_i[9:8] : glb_reg[9:8],
    wb_dat_i[7:0]};

  // read mux; unmapped addresses read zero but are still acked
  wire [31:0] rdat_next = hit_glb ? {22'h0, glb_reg}
                                  : {24'h0, ch_rd[0] | ch_rd[1]};

  // a read has its side effects at the take: the data word is captured
  // and a data read pops the queue in the same edge, so the answer that
  // follows a cycle later always shows the value from before the pop
  // writes also land at the take; the ack only tells the master it is done
  // a master that keeps stb up after ack is served again a cycle later,
  // since the take is masked only while ack is high
  // unmapped addresses are answered too, so a stray access never hangs
  // bus slave: ack one cycle after the take, dropped the next cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg  <= 1'b0;
      rdat_reg <= 32'h0;
      glb_reg  <= uartsi_pkg::GLOBAL_RST;
    end else begin
      ack_reg <= bus_req;
      if (bus_rd)
        rdat_reg <= rdat_next;
      if (bus_wr & hit_glb)
        glb_reg <= glb_next;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdat_reg;

  // per-channel slice, one copy for each of the two ports
  // map inside a slot: status at +0, data at +4, control at +8
  // status byte, high to low: available, overrun, parity, framing,
  //   receive enable, carrier, transmit empty, transmit enable
  // receive side
  //   finished characters from the external receiver enter a four-entry
  //   queue held in flip-flops; parity and framing results ride along as
  //   tags so the flags can latch only when that entry becomes the oldest
  //   a character that arrives with the queue full is dropped and marks the
  //   newest stored entry; the overrun flag shows once that entry is oldest
  //   from the drop until software clears the flag every new character is
  //   thrown away, so the queue never holds data from after the gap
  // pointers wrap on their own two bits; the count keeps a third bit so
  //   that four stored characters and an empty queue are told apart
  // parity is checked over seven or eight data bits as the format says,
  //   and the odd select only flips the expected sense
  // transmit side
  //   one holding register; a write fills it and the move to the shift
  //   register empties it again, seen by the far side as a load pulse
  //   the clear-to-send gate stalls the move as well as hiding the empty
  //   flag, so a byte never leaves while the far end refuses it
  // modem pins
  //   only channel 0 has carrier and clear-to-send; on channel 1 the gates
  //   are constant zero and the logic behind them folds away
  // the carrier rise event is kept until a status read so a short pulse
  //   on the pin still raises a request
  // halt flushes both directions and clears the receive and error flags, like a reset of
  //   the data path that leaves the programmed control bits alone
  // known limits: no break detection and no multiprocessor format here
  // interrupts
  //   each channel ors its enabled causes into one registered request; the
  //   register costs a cycle of latency but keeps the output glitch free

  for (genvar c = 0; c < 2; c++) begin : g_ch
    localparam logic [1:0] SLOT  = 2'(c);
    localparam logic [1:0] ROUTE = (c == 0) ? uartsi_pkg::ROUTE_CH0
                                            : uartsi_pkg::ROUTE_CH1;
    localparam logic       IS0   = (c == 0);

    // control bits as last written; the clear strobe bit reads back zero
    logic [5:0] ctrl_reg;
    // interrupt enables, the only writable status bits
    logic       rx_irq_enable_reg;
    logic       tx_irq_enable_reg;
    // queue storage and the per-entry error tags
    logic [7:0] q_data [4];
    logic [3:0] q_par;
    logic [3:0] q_frm;
    logic [3:0] q_mark;
    logic [1:0] wp_reg;
    logic [1:0] rp_reg;
    logic [2:0] cnt_reg;
    logic       fresh_reg;
    // sticky error flags, cleared only by the clear strobe, reset or flush
    logic       ovr_reg;
    logic       par_err_reg;
    logic       frm_err_reg;
    logic       pend_reg;
    logic       full_reg;
    logic [7:0] thr_reg;
    logic       load_reg;
    logic       dcd_reg;
    logic       dcd_prev_reg;
    logic       dcd_evt_reg;
    logic       irq_reg;

    // address decode within the channel slot
    wire in_ch    = wb_adr_i[7:6] == 2'h0 && wb_adr_i[5:4] == SLOT;
    wire hit_stat = in_ch && wb_adr_i[3:0] == uartsi_pkg::OFF_STAT;
    wire hit_data = in_ch && wb_adr_i[3:0] == uartsi_pkg::OFF_DATA;
    wire hit_ctrl = in_ch && wb_adr_i[3:0] == uartsi_pkg::OFF_CTRL;
    wire wr_stat  = bus_wr & hit_stat;
    wire wr_data  = bus_wr & hit_data;
    wire wr_ctrl  = bus_wr & hit_ctrl;
    wire rd_stat  = bus_rd & hit_stat;
    wire rd_data  = bus_rd & hit_data;
    // writing 1 to the clear bit is a one-cycle strobe, not a stored state
    wire err_clr  = wr_ctrl & wb_dat_i[uartsi_pkg::CT_ERR_CLR];

    // modem pins exist on channel 0 only; a high pin is negated
    wire dcd_high = IS0 & dcd_fn & carrier_detect_0_i;
    wire hold     = dcd_high & ~ctrl_reg[uartsi_pkg::CT_DCD_OFF];
    wire cts_gate = IS0 & cts_fn & clear_to_send_0_i
                  & ~ctrl_reg[uartsi_pkg::CT_CTS_OFF];
    wire flush    = halt | hold;

    // receive path; the whole queue is discarded while flushing
    uartsi_pkg::uartsi_rxchar_s ch;
    assign ch = rx_char_i[c];
    wire       discard = pend_reg | ovr_reg;
    wire       take    = ch.valid & ~flush & ~discard;
    wire       q_full  = cnt_reg == uartsi_pkg::Q_DEPTH;
    wire       push    = take & ~q_full;
    wire       ovr_evt = take & q_full;
    wire       pop     = rd_data & (cnt_reg != 3'h0);
    wire [2:0] cnt_next = 3'(cnt_reg + {2'h0, push} - {2'h0, pop});
    wire       head_new = (cnt_next != 3'h0) & ((cnt_reg == 3'h0) | pop) & ~flush;
    wire [1:0] wp_prev  = 2'(wp_reg - 2'h1);

    // parity over 7 or 8 data bits; odd select flips the expected sense
    wire [7:0] rx_bits = ctrl_reg[uartsi_pkg::CT_DATA8] ? ch.data
                                                         : {1'b0, ch.data[6:0]};
    wire par_bad = ctrl_reg[uartsi_pkg::CT_PAR_EN]
                 & ((^rx_bits ^ ch.parity) != ctrl_reg[uartsi_pkg::CT_PAR_ODD]);
    wire frm_bad = ~ch.stop;

    // flags latch only when an entry has just become the oldest
    wire ovr_set = fresh_reg & q_mark[rp_reg];
    wire par_set = fresh_reg & q_par[rp_reg];
    wire frm_set = fresh_reg & q_frm[rp_reg];
    wire avail   = cnt_reg != 3'h0;

    // transmit side; halt empties the holding register
    wire xfer = full_reg & tx_shift_ready_i[c] & ~cts_gate & ~halt;
    wire thre = ~full_reg & ~cts_gate;

    // dma routing that takes this channel's receive data
    wire supp = (glb_reg[uartsi_pkg::GL_SM +: 2] == uartsi_pkg::DMA_SM_IO
                 && glb_reg[uartsi_pkg::GL_SAR +: 2] == ROUTE)
              | (glb_reg[uartsi_pkg::GL_DMA1_DIR]
                 && glb_reg[uartsi_pkg::GL_IAR +: 2] == ROUTE);

    // single request line per channel
    // receive request is masked when a dma channel takes this data, but
    // error and carrier causes still interrupt so software sees the fault
    wire irq_next = (rx_irq_enable_reg & ((avail & ~supp) | ovr_reg | par_err_reg
                                | frm_err_reg | dcd_evt_reg))
                  | (tx_irq_enable_reg & thre);

    wire [7:0] stat = {avail, ovr_reg, par_err_reg, frm_err_reg,
                       rx_irq_enable_reg, dcd_reg, thre, tx_irq_enable_reg};

    // per-channel read data, zero when the slot is not addressed
    assign ch_rd[c] = hit_stat ? stat
                    : hit_data ? (avail ? q_data[rp_reg] : 8'h00)
                    : hit_ctrl ? {2'h0, ctrl_reg[5:3], 1'b0, ctrl_reg[1:0]}
                    : 8'h00;
    assign hold_w[c] = hold;

    // control and enables; status writes touch only the enable bits
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        ctrl_reg <= uartsi_pkg::CTRL_RST;
        // enables come back cleared so no request follows reset
        rx_irq_enable_reg <= 1'b0;
        tx_irq_enable_reg <= 1'b0;
      end else begin
        if (wr_ctrl)
          ctrl_reg <= wb_dat_i[5:0];
        if (wr_stat) begin
          rx_irq_enable_reg <= wb_dat_i[uartsi_pkg::ST_RXIE];
          tx_irq_enable_reg <= wb_dat_i[uartsi_pkg::ST_TXIE];
        end
      end
    end

    // queue storage; data itself needs no reset
    always_ff @(posedge clk_i) begin
      if (push)
        q_data[wp_reg] <= ch.data;
    end

    // queue tags and pointers
    always_ff @(posedge clk_i) begin
      if (rst_i | flush) begin
        q_par     <= 4'h0;
        q_frm     <= 4'h0;
        q_mark    <= 4'h0;
        wp_reg    <= 2'h0;
        rp_reg    <= 2'h0;
        cnt_reg   <= 3'h0;
        fresh_reg <= 1'b0;
      end else begin
        if (push) begin
          q_par[wp_reg]  <= par_bad;
          q_frm[wp_reg]  <= frm_bad;
          q_mark[wp_reg] <= 1'b0;
          wp_reg         <= 2'(wp_reg + 2'h1);
        end
        // the newest stored character carries the overrun marker
        if (ovr_evt)
          q_mark[wp_prev] <= 1'b1;
        if (pop)
          rp_reg <= 2'(rp_reg + 2'h1);
        cnt_reg   <= cnt_next;
        fresh_reg <= head_new;
      end
    end

    // error flags; a set in the same cycle as a clear wins
    always_ff @(posedge clk_i) begin
      if (rst_i | flush) begin
        ovr_reg  <= 1'b0;
        par_err_reg <= 1'b0;
        frm_err_reg <= 1'b0;
        pend_reg <= 1'b0;
      end else begin
        ovr_reg     <= (ovr_reg & ~err_clr) | ovr_set;
        par_err_reg <= (par_err_reg & ~err_clr) | par_set;
        frm_err_reg <= (frm_err_reg & ~err_clr) | frm_set;
        pend_reg <= (pend_reg | ovr_evt) & ~ovr_set;
      end
    end

    // transmit holding register; a write beats a same-cycle transfer
    always_ff @(posedge clk_i) begin
      if (rst_i | halt) begin
        full_reg <= 1'b0;
        thr_reg  <= 8'h00;
        load_reg <= 1'b0;
      end else begin
        load_reg <= xfer;
        if (wr_data) begin
          full_reg <= 1'b1;
          thr_reg  <= wb_dat_i[7:0];
        end else if (xfer) begin
          full_reg <= 1'b0;
        end
      end
    end

    // carrier status and its rising-edge event, both cleared by status read
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        dcd_reg      <= 1'b0;
        dcd_prev_reg <= 1'b0;
        dcd_evt_reg  <= 1'b0;
        irq_reg      <= 1'b0;
      end else begin
        dcd_prev_reg <= dcd_high;
        dcd_reg      <= dcd_high | (dcd_reg & ~rd_stat);
        dcd_evt_reg  <= (dcd_high & ~dcd_prev_reg)
                      | (dcd_evt_reg & ~rd_stat);
        irq_reg      <= irq_next;
      end
    end

    assign tx_byte_o[c] = '{load: load_reg, data: thr_reg};
    assign irq_o[c]     = irq_reg;
  end

  // the hold is registered so the output comes from a flip-flop; the
  // external receiver therefore sees it one cycle after the pin, which is
  // harmless because the queue is already being flushed in that cycle
  // receiver hold shown to the external receiver of channel 0
  always_ff @(posedge clk_i) begin
    if (rst_i)
      rx_hold_0_o <= 1'b0;
    else
      rx_hold_0_o <= hold_w[0];
  end

endmodule

// ==== uartsi_props.sv ====
// port checker for the serial status block
// assumes it is bound into uartsi_top by the statement at the foot
`timescale 1ns/1ps
module uartsi_props (
  input wire logic                        clk_i,
  input wire logic                        rst_i,
  input wire logic                        wb_cyc_i,
  input wire logic                        wb_stb_i,
  input wire logic                        wb_ack_o,
  input wire logic [1:0]                  tx_shift_ready_i,
  input uartsi_pkg::uartsi_txbyte_s [1:0] tx_byte_o,
  input wire logic                        carrier_detect_0_i,
  input wire logic                        rx_hold_0_o,
  input wire logic [1:0]                  irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // bus answer comes one cycle after the take and lasts one cycle
  a_ack_prompt: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack after request");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  // enables and holding register come out of reset cleared
  a_reset_quiet: assert property ($fell(rst_i) |-> irq_o == 2'b00 && !rx_hold_0_o)
    else $error("irq or hold set after reset");
  a_reset_txidle: assert property ($fell(rst_i) |-> !tx_byte_o[0].load [*2])
    else $error("byte moved straight after reset");
  // a byte moves only into a free shift register, one pulse per byte
  a_load_single: assert property (tx_byte_o[1].load |=> !tx_byte_o[1].load)
    else $error("load pulse too long");
  a_load_ready: assert property (tx_byte_o[0].load |-> $past(tx_shift_ready_i[0]))
    else $error("load while shift register busy");
  // receiver hold only follows a negated carrier pin
  a_hold_cause: assert property (rx_hold_0_o |-> $past(carrier_detect_0_i))
    else $error("hold without carrier loss");
  a_hold_release: assert property (!carrier_detect_0_i |=> !rx_hold_0_o)
    else $error("hold stays with carrier present");
  cover property (tx_byte_o[0].load);
  cover property ($rose(irq_o[0]));
  cover property ($rose(rx_hold_0_o));
endmodule

bind uartsi_top uartsi_props uartsi_props_i (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .tx_shift_ready_i(tx_shift_ready_i), .tx_byte_o(tx_byte_o),
  .carrier_detect_0_i(carrier_detect_0_i), .rx_hold_0_o(rx_hold_0_o), .irq_o(irq_o));

// ==== uartsi_remote.sv ====
// remote serial device: finished characters and the transmit shift registers
// assumes bench requests change right after a rising edge
`timescale 1ns/1ps
module uartsi_remote (
  input  wire logic                        clk_i,
  input  wire logic                        rst_i,
  input  wire logic [1:0]                  send_i,
  input  wire logic [7:0]                  data_i,
  input  wire logic                        odd_i,
  input  wire logic [1:0]                  bad_i,
  input  wire logic                        slow_i,
  input  uartsi_pkg::uartsi_txbyte_s [1:0] tx_i,
  output uartsi_pkg::uartsi_rxchar_s [1:0] rx_o,
  output logic      [1:0]                  ready_o
);
  logic [4:0] busy [2];
  // data outside a character is scrambled so stale bytes never pass
  always_ff @(posedge clk_i) begin
    for (int c = 0; c < 2; c++) begin
      rx_o[c].valid  <= send_i[c];
      rx_o[c].data   <= send_i[c] ? data_i : ~rx_o[c].data;
      rx_o[c].parity <= (^data_i) ^ odd_i ^ bad_i[0];
      rx_o[c].stop   <= ~bad_i[1];
      if (rst_i)
        busy[c] <= 5'h00;
      else if (tx_i[c].load)
        busy[c] <= slow_i ? 5'h14 : 5'h01;
      else if (busy[c] != 5'h00)
        busy[c] <= busy[c] - 5'h01;
    end
  end
  assign ready_o = {busy[1] == 5'h00, busy[0] == 5'h00};
endmodule

// ==== uartsi_top_tb.sv ====
// self-checking bench for the serial status block
// assumes the remote line model and the bound port checker
`timescale 1ns/1ps
module uartsi_top_tb;
  logic        clk_i, rst_i, cyc, stb, we, ack, cd, cts, odd, slow, hold;
  logic [3:0]  sel;
  logic [7:0]  adr, sdata, b, bs, ct;
  logic [7:0]  d [5];
  logic [31:0] wdat, rdat, r;
  logic [1:0]  send, bad, ready, irq;
  uartsi_pkg::uartsi_rxchar_s [1:0] rxc;
  uartsi_pkg::uartsi_txbyte_s [1:0] txb;
  int          failures = 0;
  int          total_checks = 0;
  int          c;

  uartsi_top uartsi_top_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .rx_char_i(rxc), .tx_shift_ready_i(ready), .tx_byte_o(txb),
    .carrier_detect_0_i(cd), .clear_to_send_0_i(cts), .rx_hold_0_o(hold), .irq_o(irq));
  uartsi_remote uartsi_remote_i (.clk_i(clk_i), .rst_i(rst_i), .send_i(send), .data_i(sdata),
    .odd_i(odd), .bad_i(bad), .slow_i(slow), .tx_i(txb), .rx_o(rxc), .ready_o(ready));

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("Error at %0t: expected %h got %h", $time, e, g);
    end
  endtask

  // one classic cycle; the wait for ack is cut short by the watchdog only
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] v);
    we <= w;
    adr <= a;
    wdat <= v;
    sel <= 4'hf;
    cyc <= 1'b1;
    stb <= 1'b1;
    do @(posedge clk_i); while (ack !== 1'b1);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    wb(1'b1, a, v);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    wb(1'b0, a, 32'h0);
    chk({24'h0, e}, r);
  endtask

  task automatic snd(input int ch, input logic [7:0] v, input logic [1:0] bv);
    sdata <= v;
    bad <= bv;
    send[ch] <= 1'b1;
    @(posedge clk_i);
    send <= 2'b00;
    repeat (3) @(posedge clk_i);
  endtask

  task automatic done(input string nm);
    $display("test %s finished, %0d failures so far", nm, failures);
  endtask

  task automatic give_verdict();
    $display("checks %0d, failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // the whole run needs well under 3000 cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    failures++;
    give_verdict();
  end

  initial begin
    {cyc, stb, we, cd, cts, odd, slow, send, bad} = 11'h000;
    {sel, adr, sdata, wdat} = 52'h0;
    rst_i = 1'b1;
    c = $urandom(79);
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(8'h00, 8'h02);
    rd(8'h10, 8'h02);
    rd(8'h30, 8'h00);
    done("reset");
    c = $urandom % 2;
    bs = c ? 8'h10 : 8'h00;
    b = $urandom;
    wr(bs, {24'h0, b});
    rd(bs, b & 8'h09 | 8'h02);
    chk(b[0], irq[c]);
    wr(bs, 32'h0);
    odd = $urandom;
    ct = {2'b00, 1'b1, 3'b000, odd, 1'b1};
    wr(bs + 8'h08, {24'h0, ct});
    // every mix of parity and stop faults
    for (int k = 0; k < 4; k++) begin
      b = $urandom;
      snd(c, b, k[1:0]);
      rd(bs, {2'b10, k[0], k[1], 4'h2});
      rd(bs + 8'h04, b);
      rd(bs, {2'b00, k[0], k[1], 4'h2});
      wr(bs + 8'h08, {24'h0, ct | 8'h04});
      rd(bs, 8'h02);
    end
    done("receive");
    // five characters into a four-deep queue, the second badly framed
    for (int k = 0; k < 5; k++) begin
      d[k] = $urandom;
      snd(c, d[k], {k == 1, 1'b0});
    end
    rd(bs, 8'h82);
    rd(bs + 8'h04, d[0]);
    rd(bs, 8'h92);
    rd(bs + 8'h04, d[1]);
    rd(bs + 8'h04, d[2]);
    rd(bs, 8'hd2);
    rd(bs + 8'h04, d[3]);
    snd(c, 8'h3c, 2'b00);
    rd(bs, 8'h52);
    wr(bs + 8'h08, {24'h0, ct | 8'h04});
    snd(c, d[4], 2'b00);
    rd(bs, 8'h82);
    rd(bs + 8'h04, d[4]);
    done("overrun");
    wr(bs, 32'h08);
    snd(c, d[0], 2'b00);
    chk(1'b1, irq[c]);
    rd(bs + 8'h04, d[0]);
    chk(1'b0, irq[c]);
    // both routing forms of the dma request select
    for (int k = 0; k < 2; k++) begin
      wr(8'h20, k ? 32'h40 | (c + 1) << 7 : 32'h0c | (c + 1) << 4);
      snd(c, d[1], 2'b00);
      chk(1'b0, irq[c]);
      rd(bs + 8'h04, d[1]);
    end
    wr(8'h20, 32'h0);
    wr(bs, 32'h0);
    done("interrupt");
    cts <= 1'b1;
    @(posedge clk_i);
    rd(8'h00, 8'h00);
    wr(8'h04, {24'h0, d[2]});
    cts <= 1'b0;
    for (int k = 0; k < 20 && txb[0].load !== 1'b1; k++) @(posedge clk_i);
    chk(d[2], txb[0].data);
    rd(8'h00, 8'h02);
    slow <= 1'b1;
    wr(8'h14, {24'h0, d[3]});
    wr(8'h14, {24'h0, d[4]});
    rd(8'h10, 8'h00);
    wr(8'h20, 32'h1);
    rd(8'h10, 8'h02);
    wr(8'h20, 32'h0);
    slow <= 1'b0;
    done("transmit");
    snd(0, d[0], 2'b00);
    cd <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk(1'b1, hold);
    rd(8'h00, 8'h06);
    cd <= 1'b0;
    rd(8'h00, 8'h06);
    rd(8'h00, 8'h02);
    wr(8'h00, 32'h08);
    cd <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk(1'b1, irq[0]);
    done("carrier");
    give_verdict();
  end
endmodule
